// ==== bench/circ_addr_chk.sv ====
// Port-level checker for the circular address generator.
module circ_addr_chk (
	input wire sys_clk,
	input wire resetn,
	input wire [4:0] reg_addr,
	input wire reg_rd,
	input wire reg_wr,
	input wire [31:0] reg_rdata,
	input wire upd_valid,
	input wire [3:0] upd_ptr_sel,
	input wire [22:0] data_addr_r,
	input wire data_addr_valid_r,
	input wire data_addr_circ_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire req = upd_valid && upd_ptr_sel <= 4'h8;
	////////////////////////////////////////////////////////////////
	a_valid_pulse: assert property (req |=> data_addr_valid_r)
		else $error("No address after an update request.");
	a_no_spurious: assert property (!req |=> !data_addr_valid_r)
		else $error("Address valid without an accepted request.");
	a_addr_hold: assert property (!data_addr_valid_r |-> $stable(data_addr_r) && $stable(data_addr_circ_r))
		else $error("Address changed without a request.");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("Read data outside the read answer cycle.");
	a_status_bits: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata[31:9] == 23'h0)
		else $error("Status read shows bits above bit 8.");
	a_mode_bits: assert property (reg_rd && reg_addr == 5'h01 |=> reg_rdata[31:1] == 31'h0)
		else $error("Mode read shows bits above bit 0.");
	a_size_bits: assert property (reg_rd && reg_addr inside {[5'h02:5'h09]} |=> reg_rdata[31:16] == 16'h0)
		else $error("Size or start read wider than 16 bits.");
	a_xptr_bits: assert property (reg_rd && reg_addr inside {[5'h0A:5'h12]} |=> reg_rdata[31:23] == 9'h0)
		else $error("Pointer read wider than 23 bits.");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 5'h12 |=> reg_rdata == 32'h0)
		else $error("Unmapped read not zero.");
	// Two linear updates of one pointer two cycles apart, with no bus write in either update cycle, must stay on one page.
	a_page_kept: assert property ((req && !reg_wr) ##2 (upd_valid && upd_ptr_sel == $past(upd_ptr_sel, 2) && !reg_wr)
		|=> data_addr_circ_r || $past(data_addr_circ_r, 2) || data_addr_r[22:16] == $past(data_addr_r[22:16], 2))
		else $error("Linear update crossed a page.");
endmodule
bind circular_address_generator circ_addr_chk u_chk (.sys_clk, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_rdata,
	.upd_valid, .upd_ptr_sel, .data_addr_r, .data_addr_valid_r, .data_addr_circ_r);

// ==== bench/test_circular_address_generator.sv ====
// Directed testbench for the circular address generator.
module test_circular_address_generator;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, resetn, reg_wr, reg_rd, upd_valid, upd_sub, upd_force_circ;
	logic [4:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [3:0] upd_ptr_sel;
	logic [15:0] upd_step;
	wire [31:0] reg_rdata;
	wire [22:0] data_addr_r;
	wire data_addr_valid_r, data_addr_circ_r;
	int fails, num_checks, i;
	circular_address_generator dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.upd_valid, .upd_ptr_sel, .upd_step, .upd_sub, .upd_force_circ, .data_addr_r, .data_addr_valid_r,
		.data_addr_circ_r);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so it is sampled just past that edge.
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	endtask
	task automatic upd(input logic [3:0] s, input logic [15:0] st, input logic sb, input logic f,
		input logic [22:0] ea, input logic ec);
		@(posedge sys_clk);
		upd_valid <= 1'b1;
		upd_ptr_sel <= s;
		upd_step <= st;
		upd_sub <= sb;
		upd_force_circ <= f;
		@(posedge sys_clk);
		upd_valid <= 1'b0;
		#1 chk("valid", {31'h0, s <= 4'h8}, {31'h0, data_addr_valid_r});
		if (s <= 4'h8) begin
			chk("addr", {9'h0, ea}, {9'h0, data_addr_r});
			chk("circ", {31'h0, ec}, {31'h0, data_addr_circ_r});
		end
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		{resetn, reg_wr, reg_rd, upd_valid, upd_sub, upd_force_circ} = 6'h00;
		reg_addr = 5'h00;
		reg_wdata = 32'h0;
		upd_ptr_sel = 4'h0;
		upd_step = 16'h0;
		fails = 0;
		num_checks = 0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(5'h00, 32'h0);
		wr(5'h00, 32'hFFFFFFFF);
		rd(5'h00, 32'h000001FF);
		wr(5'h01, 32'hFFFFFFFF);
		rd(5'h01, 32'h00000001);
		wr(5'h02, 32'hFFFFFFFF);
		rd(5'h02, 32'h0000FFFF);
		wr(5'h0A, 32'hFFFFFFFF);
		rd(5'h0A, 32'h007FFFFF);
		wr(5'h14, 32'hFFFFFFFF);
		rd(5'h14, 32'h0);
		// Pointer 1, 4 and the coefficient pointer circular; 2 and 3 linear.
		wr(5'h00, 32'h112);
		wr(5'h01, 32'h0);
		wr(5'h02, 32'h3);
		wr(5'h03, 32'h5);
		wr(5'h04, 32'h2);
		wr(5'h05, 32'h0A02);
		wr(5'h07, 32'h2);
		wr(5'h09, 32'h10);
		wr(5'h0B, 32'h010000);
		wr(5'h0C, 32'h020002);
		wr(5'h0D, 32'h03FFFF);
		wr(5'h0E, 32'h010A01);
		wr(5'h12, 32'h050001);
		for (i = 0; i < 4; i++)
			upd(4'h1, 16'h1, 1'b0, 1'b0, 23'h010A02 + 23'(i % 3), 1'b1);
		rd(5'h0B, 32'h010001);
		upd(4'h1, 16'h2, 1'b1, 1'b0, 23'h010A03, 1'b1);
		upd(4'h1, 16'h0, 1'b0, 1'b0, 23'h010A04, 1'b1);
		upd(4'h2, 16'h1, 1'b0, 1'b0, 23'h020002, 1'b0);
		upd(4'h2, 16'h1, 1'b0, 1'b0, 23'h020003, 1'b0);
		wr(5'h0C, 32'h020002);
		upd(4'h2, 16'h1, 1'b0, 1'b1, 23'h020002, 1'b1);
		upd(4'h2, 16'h1, 1'b0, 1'b1, 23'h020000, 1'b1);
		upd(4'h3, 16'h1, 1'b0, 1'b0, 23'h03FFFF, 1'b0);
		upd(4'h3, 16'h1, 1'b0, 1'b0, 23'h030000, 1'b0);
		// Without legacy mode pointer 4 wraps at the five entries of the high size register.
		upd(4'h4, 16'h4, 1'b0, 1'b0, 23'h010A03, 1'b1);
		rd(5'h0E, 32'h00010A00);
		wr(5'h0E, 32'h010A01);
		// Legacy mode makes pointer 4 wrap at three entries instead of five.
		wr(5'h01, 32'h1);
		for (i = 0; i < 3; i++)
			upd(4'h4, 16'h1, 1'b0, 1'b0, 23'h010A02 + 23'((i + 1) % 3), 1'b1);
		upd(4'h8, 16'h1, 1'b0, 1'b0, 23'h050011, 1'b1);
		upd(4'h8, 16'h1, 1'b0, 1'b0, 23'h050010, 1'b1);
		upd(4'h9, 16'h1, 1'b0, 1'b0, 23'h0, 1'b0);
		final_report();
	end
endmodule

// ==== core/circ_addr_regs.vh ====
// Register offsets, field positions, reset values and widths of the circular address generator.
`ifndef CIRC_ADDR_REGS_VH
`define CIRC_ADDR_REGS_VH

`define CAG_ADDR_W 5
`define CAG_DATA_W 32

`define CAG_OFS_STATUS 5'h00
`define CAG_OFS_MODE 5'h01
`define CAG_OFS_SIZE_LOW 5'h02
`define CAG_OFS_SIZE_HIGH 5'h03
`define CAG_OFS_SIZE_COEF 5'h04
`define CAG_OFS_START_PAIR0 5'h05
`define CAG_OFS_START_PAIR1 5'h06
`define CAG_OFS_START_PAIR2 5'h07
`define CAG_OFS_START_PAIR3 5'h08
`define CAG_OFS_START_COEF 5'h09
`define CAG_OFS_XPTR_FIRST 5'h0A
`define CAG_OFS_XPTR_COEF 5'h12

`define CAG_STATUS_COEF_BIT 8
`define CAG_STATUS_W 9
`define CAG_MODE_LEGACY_BIT 0

`define CAG_PTR_COEF 4'h8
`define CAG_PTR_LAST 4'h8

`define CAG_RST_STATUS 9'h000
`define CAG_RST_MODE 1'b0
`define CAG_RST_SIZE 16'h0000
`define CAG_RST_START 16'h0000
`define CAG_RST_XPTR 23'h000000

`define CAG_PAGE_HI 22
`define CAG_PAGE_LO 16

`endif

// ==== core/circular_address_generator.v ====
// Pointer update and data address generation with linear and circular buffer modes.

`include "circ_addr_regs.vh"

module circular_address_generator (
	input wire sys_clk,
	input wire resetn,
	input wire [`CAG_ADDR_W-1:0] reg_addr,
	input wire [`CAG_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`CAG_DATA_W-1:0] reg_rdata,
	input wire upd_valid,
	input wire [3:0] upd_ptr_sel,
	input wire [15:0] upd_step,
	input wire upd_sub,
	input wire upd_force_circ,
	output reg [22:0] data_addr_r,
	output reg data_addr_valid_r,
	output reg data_addr_circ_r
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Smallest all-ones mask that covers the size, i.e. 2^N - 1 with 2^N > size.
	function [15:0] buf_mask;
		input [15:0] r;
		reg [15:0] m;
		begin
			m = r;
			m = m | (m >> 1);
			m = m | (m >> 2);
			m = m | (m >> 4);
			m = m | (m >> 8);
			buf_mask = m;
		end
	endfunction

	// Circular step of a 16-bit pointer; the bits above the mask stay as the aligned top.
	function [15:0] circ_step;
		input [15:0] p;
		input [15:0] s;
		input [15:0] r;
		reg [15:0] m;
		reg [17:0] sum;
		begin
			m = buf_mask(r);
			sum = {2'b00, p & m} + {{2{s[15]}}, s};
			if (sum[17]) begin
				sum = sum + {2'b00, r};
			end else if (sum[16:0] >= {1'b0, r}) begin
				sum = sum - {2'b00, r};
			end
			circ_step = (p & ~m) | (sum[15:0] & m);
		end
	endfunction

	// True for the offsets of the nine extended pointers.
	function is_xptr_ofs;
		input [`CAG_ADDR_W-1:0] a;
		begin
			is_xptr_ofs = (a >= `CAG_OFS_XPTR_FIRST) && (a <= `CAG_OFS_XPTR_COEF);
		end
	endfunction

	// Pointer number that an extended pointer offset addresses.
	function [3:0] xptr_slot;
		input [`CAG_ADDR_W-1:0] a;
		reg [`CAG_ADDR_W-1:0] d;
		begin
			d = a - `CAG_OFS_XPTR_FIRST;
			xptr_slot = d[3:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Software-visible state.

	reg [`CAG_STATUS_W-1:0] status_r;
	reg legacy_r;
	reg [15:0] size_low_r;
	reg [15:0] size_high_r;
	reg [15:0] size_coef_r;
	reg [15:0] start_r [0:3];
	reg [15:0] start_coef_r;
	reg [22:0] xptr_r [0:8];

	////////////////////////////////////////////////////////////////////////////////
	// Pointer selection and next-value logic.

	wire sel_ok = (upd_ptr_sel <= `CAG_PTR_LAST);
	wire is_coef = (upd_ptr_sel == `CAG_PTR_COEF);
	wire [3:0] sel_idx = sel_ok ? upd_ptr_sel : 4'h0;
	wire [22:0] cur = xptr_r[sel_idx];

	reg circ_en;
	reg [15:0] size_sel;
	reg [15:0] start_sel;
	reg [15:0] step_eff;
	reg [15:0] new_low;
	reg [22:0] addr_nxt;
	reg use_circ;

	always @* begin
		circ_en = upd_force_circ | (is_coef ? status_r[`CAG_STATUS_COEF_BIT] : status_r[sel_idx[2:0]]);
		if (is_coef) begin
			size_sel = size_coef_r;
			start_sel = start_coef_r;
		end else if (sel_idx[2] && !legacy_r) begin
			size_sel = size_high_r;
			start_sel = start_r[sel_idx[2:1]];
		end else begin
			// Legacy mode lets the low size register serve the upper four pointers too.
			size_sel = size_low_r;
			start_sel = start_r[sel_idx[2:1]];
		end
	end

	always @* begin
		if (upd_sub) begin
			// The two's complement of 8000h is itself, so subtracting it gives the same step as adding it; software avoids it.
			step_eff = ~upd_step + 16'h0001;
		end else begin
			step_eff = upd_step;
		end
		// A zero size cannot describe a buffer, so such a pointer falls back to linear stepping.
		use_circ = circ_en & (size_sel != 16'h0000);
		if (use_circ) begin
			new_low = circ_step(cur[15:0], step_eff, size_sel);
			addr_nxt = {cur[`CAG_PAGE_HI:`CAG_PAGE_LO], 16'h0000} + {7'h00, start_sel} + {7'h00, cur[15:0]};
		end else begin
			new_low = cur[15:0] + step_eff;
			addr_nxt = cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and pointer updates.

	wire wr_xptr = reg_wr && is_xptr_ofs(reg_addr);
	wire [3:0] wr_slot = xptr_slot(reg_addr);
	wire upd_take = upd_valid && sel_ok;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			status_r <= `CAG_RST_STATUS;
			legacy_r <= `CAG_RST_MODE;
		end else if (reg_wr) begin
			if (reg_addr == `CAG_OFS_STATUS) begin
				status_r <= reg_wdata[`CAG_STATUS_W-1:0];
			end
			if (reg_addr == `CAG_OFS_MODE) begin
				legacy_r <= reg_wdata[`CAG_MODE_LEGACY_BIT];
			end
		end
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			size_low_r <= `CAG_RST_SIZE;
			size_high_r <= `CAG_RST_SIZE;
			size_coef_r <= `CAG_RST_SIZE;
		end else if (reg_wr) begin
			case (reg_addr)
				`CAG_OFS_SIZE_LOW: begin
					size_low_r <= reg_wdata[15:0];
				end
				`CAG_OFS_SIZE_HIGH: begin
					size_high_r <= reg_wdata[15:0];
				end
				`CAG_OFS_SIZE_COEF: begin
					size_coef_r <= reg_wdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Start registers may hold any offset, so a buffer need not sit on an aligned boundary.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			start_r[0] <= `CAG_RST_START;
			start_r[1] <= `CAG_RST_START;
			start_r[2] <= `CAG_RST_START;
			start_r[3] <= `CAG_RST_START;
			start_coef_r <= `CAG_RST_START;
		end else if (reg_wr) begin
			case (reg_addr)
				`CAG_OFS_START_PAIR0: begin
					start_r[0] <= reg_wdata[15:0];
				end
				`CAG_OFS_START_PAIR1: begin
					start_r[1] <= reg_wdata[15:0];
				end
				`CAG_OFS_START_PAIR2: begin
					start_r[2] <= reg_wdata[15:0];
				end
				`CAG_OFS_START_PAIR3: begin
					start_r[3] <= reg_wdata[15:0];
				end
				`CAG_OFS_START_COEF: begin
					start_coef_r <= reg_wdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Pointer words, written by software and stepped by the update port.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			xptr_r[0] <= `CAG_RST_XPTR;
			xptr_r[1] <= `CAG_RST_XPTR;
			xptr_r[2] <= `CAG_RST_XPTR;
			xptr_r[3] <= `CAG_RST_XPTR;
			xptr_r[4] <= `CAG_RST_XPTR;
			xptr_r[5] <= `CAG_RST_XPTR;
			xptr_r[6] <= `CAG_RST_XPTR;
			xptr_r[7] <= `CAG_RST_XPTR;
			xptr_r[8] <= `CAG_RST_XPTR;
		end else begin
			// A pointer update lands first so that a software load in the same cycle overrides it.
			if (upd_take) begin
				xptr_r[sel_idx] <= {cur[`CAG_PAGE_HI:`CAG_PAGE_LO], new_low};
			end
			if (wr_xptr) begin
				xptr_r[wr_slot] <= reg_wdata[22:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address output.

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_addr_valid_r <= 1'b0;
		end else begin
			data_addr_valid_r <= upd_take;
		end
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_addr_r <= 23'h000000;
		end else if (upd_take) begin
			data_addr_r <= addr_nxt;
		end
	end

	// Holds the mode of the last accepted update so a consumer can tell wrapped addresses apart.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_addr_circ_r <= 1'b0;
		end else if (upd_take) begin
			data_addr_circ_r <= use_circ;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read-back; unmapped offsets read as zero.

	reg [`CAG_DATA_W-1:0] rd_val;

	always @* begin
		rd_val = 32'h00000000;
		case (reg_addr)
			`CAG_OFS_STATUS: begin
				rd_val = {23'h000000, status_r};
			end
			`CAG_OFS_MODE: begin
				rd_val = {31'h00000000, legacy_r};
			end
			`CAG_OFS_SIZE_LOW: begin
				rd_val = {16'h0000, size_low_r};
			end
			`CAG_OFS_SIZE_HIGH: begin
				rd_val = {16'h0000, size_high_r};
			end
			`CAG_OFS_SIZE_COEF: begin
				rd_val = {16'h0000, size_coef_r};
			end
			`CAG_OFS_START_PAIR0: begin
				rd_val = {16'h0000, start_r[0]};
			end
			`CAG_OFS_START_PAIR1: begin
				rd_val = {16'h0000, start_r[1]};
			end
			`CAG_OFS_START_PAIR2: begin
				rd_val = {16'h0000, start_r[2]};
			end
			`CAG_OFS_START_PAIR3: begin
				rd_val = {16'h0000, start_r[3]};
			end
			`CAG_OFS_START_COEF: begin
				rd_val = {16'h0000, start_coef_r};
			end
			default: begin
				if (is_xptr_ofs(reg_addr)) begin
					rd_val = {9'h000, xptr_r[xptr_slot(reg_addr)]};
				end
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe and are zero otherwise.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= rd_val;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule
